// ---- lcd_mem_model.sv ----
`timescale 1ns/100ps
`include "lcd_refresh_defines.svh"
module lcd_mem_model
  import lcd_refresh_pkg::*;
(
  input  wire logic               hclk,
  input  wire host_mem_t          host_mem,
  input  wire logic [`ADDR_W-1:0] mem_rd_addr,
  output logic [7:0]              mem_rdata
);
  logic [7:0] mem [0:65535];

  // Unwritten bytes hold the inverted low address byte, so stale data from an
  // earlier read of an address with another low byte cannot pass for a fresh one.
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = ~i[7:0];
    end
  end

  assign mem_rdata = mem[mem_rd_addr];

  always @(posedge hclk) begin
    if (host_mem.we === 1'b1) begin
      mem[host_mem.addr] <= host_mem.wdata;
    end
  end
endmodule : lcd_mem_model

// ---- lcd_refresh_address_cursor.sv ----
`timescale 1ns/100ps
`include "lcd_refresh_defines.svh"
module lcd_refresh_address_cursor
  import lcd_refresh_pkg::*;
#(
  parameter int HIDE_CYCLES = `CURSOR_HIDE_MS * 1000000 / `CLK_PERIOD_NS
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire logic [7:0]         mem_rdata,
  output logic [`ADDR_W-1:0]      mem_rd_addr,
  output host_mem_t               host_mem,
  output fetch_t                  fetch,
  output logic                    fetch_valid,
  output logic                    line_latch_pulse,
  output logic                    frame_start
);
  ctrl_t              ctrl_reg;
  logic [`ADDR_W-1:0] blk_reg [0:3];
  logic [7:0]         pitch_reg, range_reg, total_reg;
  logic [8:0]         lines_reg, sl1_reg;
  logic [3:0]         fx_reg;
  logic [11:0]        dots_reg;
  logic [`ADDR_W-1:0] cursor_reg, wr_addr_reg;
  logic               dp_wr_reg;
  logic [7:0]         dp_addr_reg;
  logic [31:0]        hrdata_reg, rd_word;
  host_mem_t          host_mem_reg;
  logic [4:0]         div_cnt_reg;
  logic [7:0]         col_reg;
  logic [8:0]         line_reg;
  logic [`ADDR_W-1:0] base_a_reg, base_b_reg;
  logic [11:0]        dot_pos_reg;
  fetch_t             fetch_reg;
  logic               fetch_valid_reg, lp_reg, frame_reg;
  logic [21:0]        hide_cnt_reg;
  logic               acc, acc_mem, fetch_en, line_end, in_fetch;
  logic               tcr_error, hidden, hit;
  logic [5:0]         period;
  logic [4:0]         div_last;
  logic [8:0]         fetch_cols;
  logic [11:0]        dots_left, osc_line;
  logic [3:0]         valid_dots;
  logic [`ADDR_W-1:0] addr_a, addr_b, cap_addr, step;

  assign acc       = hsel && hready && htrans[1];
  assign acc_mem   = acc && (haddr[7:0] == `OFF_MEMDATA);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_reg   <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata_reg  <= 32'h0000_0000;
    end else begin
      dp_wr_reg   <= acc && hwrite;
      dp_addr_reg <= haddr[7:0];
      hrdata_reg  <= (acc && !hwrite) ? rd_word : 32'h0000_0000;
    end
  end

  assign osc_line = 12'(total_reg) * `OSC_PER_ADDR + `OSC_EXTRA;

  always_comb begin
    unique case (haddr[7:0])
      `OFF_CTRL:    rd_word = {23'h0, ctrl_reg};
      `OFF_BLK1:    rd_word = {16'h0, blk_reg[0]};
      `OFF_BLK2:    rd_word = {16'h0, blk_reg[1]};
      `OFF_BLK3:    rd_word = {16'h0, blk_reg[2]};
      `OFF_BLK4:    rd_word = {16'h0, blk_reg[3]};
      `OFF_PITCH:   rd_word = {24'h0, pitch_reg};
      `OFF_RANGE:   rd_word = {24'h0, range_reg};
      `OFF_TOTAL:   rd_word = {24'h0, total_reg};
      `OFF_LINES:   rd_word = {23'h0, lines_reg};
      `OFF_SL1:     rd_word = {23'h0, sl1_reg};
      `OFF_FX:      rd_word = {28'h0, fx_reg};
      `OFF_DOTS:    rd_word = {20'h0, dots_reg};
      `OFF_CURSOR:  rd_word = {16'h0, cursor_reg};
      `OFF_MEMDATA: rd_word = {24'h0, mem_rdata};
      `OFF_STATUS:  rd_word = {4'h0, osc_line, 14'h0, hidden, tcr_error};
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg  <= `CTRL_RST;
      pitch_reg <= `PITCH_RST;
      range_reg <= `RANGE_RST;
      total_reg <= `TOTAL_RST;
      lines_reg <= `LINES_RST;
      sl1_reg   <= `SL1_RST;
      fx_reg    <= `FX_RST;
      dots_reg  <= `DOTS_RST;
    end else if (dp_wr_reg) begin
      unique case (dp_addr_reg)
        `OFF_CTRL:  ctrl_reg  <= ctrl_t'(hwdata[8:0]);
        `OFF_PITCH: pitch_reg <= hwdata[7:0];
        `OFF_RANGE: range_reg <= hwdata[7:0];
        `OFF_TOTAL: total_reg <= hwdata[7:0];
        `OFF_LINES: lines_reg <= hwdata[8:0];
        `OFF_SL1:   sl1_reg   <= hwdata[8:0];
        `OFF_FX:    fx_reg    <= hwdata[3:0];
        `OFF_DOTS:  dots_reg  <= hwdata[11:0];
        default:    ;
      endcase
    end
  end

  // Block start addresses; a block written mid-frame takes effect when the
  // scan next enters that block, so scrolling never tears a line.
  for (genvar b = 0; b < 4; b++) begin : g_blk
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        blk_reg[b] <= '0;
      end else if (dp_wr_reg && dp_addr_reg == `OFF_BLK1 + 8'(4 * b)) begin
        blk_reg[b] <= hwdata[`ADDR_W-1:0];
      end
    end
  end

  always_comb begin
    unique case (ctrl_reg.dir)
      DIR_RIGHT: step = `ADDR_W'(1);
      DIR_LEFT:  step = {`ADDR_W{1'b1}};
      DIR_UP:    step = -`ADDR_W'(pitch_reg);
      DIR_DOWN:  step = `ADDR_W'(pitch_reg);
    endcase
  end

  // The cursor doubles as the host access pointer, so a host memory data access moves
  // the on-screen cursor too. A cursor write in its data phase wins over a
  // step taken by the next access in the same edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cursor_reg  <= '0;
      wr_addr_reg <= '0;
    end else begin
      if (acc_mem) begin
        wr_addr_reg <= cursor_reg;
        cursor_reg  <= cursor_reg + step;
      end
      if (dp_wr_reg && dp_addr_reg == `OFF_CURSOR) begin
        cursor_reg <= hwdata[`ADDR_W-1:0];
      end
    end
  end

  assign mem_rd_addr = cursor_reg;
  assign host_mem    = host_mem_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_mem_reg <= '0;
    end else begin
      host_mem_reg.we    <= dp_wr_reg && dp_addr_reg == `OFF_MEMDATA;
      host_mem_reg.addr  <= wr_addr_reg;
      host_mem_reg.wdata <= hwdata[7:0];
    end
  end

  assign period   = `FETCH_BASE_CYCLES << ctrl_reg.div_sel;
  assign div_last = 5'(period - 6'h01);
  assign fetch_en = ctrl_reg.enable && div_cnt_reg == div_last;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= 5'h00;
    end else if (!ctrl_reg.enable || fetch_en) begin
      div_cnt_reg <= 5'h00;
    end else begin
      div_cnt_reg <= div_cnt_reg + 5'h01;
    end
  end

  assign fetch_cols = {1'b0, range_reg} + 9'(ctrl_reg.hdot_shift);
  assign in_fetch   = {1'b0, col_reg} < fetch_cols;
  assign line_end   = fetch_en && col_reg == total_reg;
  assign tcr_error  = {1'b0, total_reg} < {1'b0, range_reg} + `TOTAL_MARGIN;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      col_reg     <= 8'h00;
      dot_pos_reg <= 12'h000;
    end else if (!ctrl_reg.enable || line_end) begin
      col_reg     <= 8'h00;
      dot_pos_reg <= 12'h000;
    end else if (fetch_en) begin
      col_reg     <= col_reg + 8'h01;
      dot_pos_reg <= dot_pos_reg + 12'(fx_reg);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_reg   <= 9'h000;
      base_a_reg <= '0;
      base_b_reg <= '0;
    end else if (!ctrl_reg.enable ||
                 (line_end && line_reg == lines_reg - 9'h001)) begin
      line_reg   <= 9'h000;
      base_a_reg <= blk_reg[0];
      base_b_reg <= blk_reg[1];
    end else if (line_end && line_reg + 9'h001 == sl1_reg) begin
      line_reg   <= line_reg + 9'h001;
      base_a_reg <= blk_reg[2];
      base_b_reg <= blk_reg[3];
    end else if (line_end) begin
      line_reg   <= line_reg + 9'h001;
      base_a_reg <= base_a_reg + `ADDR_W'(pitch_reg);
      base_b_reg <= base_b_reg + `ADDR_W'(pitch_reg);
    end
  end

  assign addr_a    = base_a_reg + `ADDR_W'(col_reg);
  assign addr_b    = base_b_reg + `ADDR_W'(col_reg);
  assign cap_addr  = ctrl_reg.three_layer ? addr_b : addr_a;
  assign hit       = fetch_en && in_fetch && cap_addr == cursor_reg;
  assign dots_left = dots_reg - dot_pos_reg;
  assign hidden    = hide_cnt_reg >= 22'(HIDE_CYCLES);

  always_comb begin
    if (dot_pos_reg >= dots_reg) begin
      valid_dots = 4'h0;
    end else if (dots_left < 12'(fx_reg)) begin
      valid_dots = dots_left[3:0];
    end else begin
      valid_dots = fx_reg;
    end
  end

  // The absence timer runs even while the cursor is switched off, so that
  // switching it on again does not flash a stale cursor.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hide_cnt_reg <= 22'h000000;
    end else if (hit) begin
      hide_cnt_reg <= 22'h000000;
    end else if (!hidden) begin
      hide_cnt_reg <= hide_cnt_reg + 22'h000001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_reg       <= '0;
      fetch_valid_reg <= 1'b0;
      lp_reg          <= 1'b0;
      frame_reg       <= 1'b0;
    end else begin
      fetch_valid_reg <= fetch_en && in_fetch;
      lp_reg          <= line_end && !tcr_error;
      frame_reg       <= line_end && line_reg == lines_reg - 9'h001;
      if (fetch_en && in_fetch) begin
        fetch_reg.addr_a     <= addr_a;
        fetch_reg.addr_b     <= addr_b;
        fetch_reg.show_a     <= !ctrl_reg.gfx_cursor;
        fetch_reg.cursor     <= hit && ctrl_reg.cursor_on && !hidden;
        fetch_reg.valid_dots <= valid_dots;
      end
    end
  end

  assign fetch            = fetch_reg;
  assign fetch_valid      = fetch_valid_reg;
  assign line_latch_pulse = lp_reg;
  assign frame_start      = frame_reg;

  logic [5:0] gap_reg;
  logic       seen_reg;
  div_sel_t   last_sel_reg;
  logic [8:0] nfetch_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_reg      <= 6'h00;
      seen_reg     <= 1'b0;
      last_sel_reg <= DIV_4;
      nfetch_reg   <= 9'h000;
    end else begin
      gap_reg      <= fetch_en ? 6'h00 : gap_reg + 6'h01;
      seen_reg     <= ctrl_reg.enable && (seen_reg || fetch_en);
      last_sel_reg <= ctrl_reg.div_sel;
      nfetch_reg   <= (line_end || !ctrl_reg.enable) ? 9'h000 :
                      nfetch_reg + 9'(fetch_en && in_fetch);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_DIV4: assert property (
    seen_reg && fetch_en && ctrl_reg.div_sel == DIV_4 &&
    last_sel_reg == DIV_4 |-> gap_reg == 6'h07)
    else $error("fetch spacing wrong at divide 1/4");
  AST_DIV8: assert property (
    seen_reg && fetch_en && ctrl_reg.div_sel == DIV_8 &&
    last_sel_reg == DIV_8 |-> gap_reg == 6'h0f)
    else $error("fetch spacing wrong at divide 1/8");
  AST_DIV16: assert property (
    seen_reg && fetch_en && ctrl_reg.div_sel == DIV_16 &&
    last_sel_reg == DIV_16 |-> gap_reg == 6'h1f)
    else $error("fetch spacing wrong at divide 1/16");
  AST_STEP_RIGHT: assert property (
    acc_mem && ctrl_reg.dir == DIR_RIGHT && !dp_wr_reg
    |=> cursor_reg == $past(cursor_reg) + `ADDR_W'(1))
    else $error("cursor did not step right");
  AST_WR_ADDR: assert property (
    acc_mem && hwrite |=> ##1 host_mem.we &&
    host_mem.addr == $past(cursor_reg, 2))
    else $error("host write not at cursor address");
  AST_CURSOR_LAYER: assert property (
    fetch_valid && fetch.cursor |-> (ctrl_reg.three_layer ?
    fetch.addr_b : fetch.addr_a) == $past(cursor_reg))
    else $error("cursor drawn off its layer");
  AST_HIDE: assert property (
    hidden && !hit |=> !(fetch_valid && fetch.cursor))
    else $error("cursor shown after absence limit");
  AST_LP_ERR: assert property (
    line_end && tcr_error |=> !line_latch_pulse)
    else $error("line pulse with short line time");
  AST_FETCH_COUNT: assert property (
    line_end && !tcr_error |-> nfetch_reg == fetch_cols)
    else $error("wrong number of fetches per line");
  AST_BLOCK2: assert property (
    fetch_en && col_reg == 8'h00 && line_reg == sl1_reg &&
    $stable(blk_reg[2]) |=> fetch.addr_a == blk_reg[2])
    else $error("second block start not used");
  AST_DOTS: assert property (
    fetch_valid |-> fetch.valid_dots <= fx_reg)
    else $error("valid dots exceed field width");

  COV_LINE: cover property (line_latch_pulse);
  COV_CURSOR: cover property (fetch_valid && fetch.cursor);
  COV_HOST_WR: cover property (host_mem.we);
  COV_HIDDEN: cover property ($rose(hidden));
endmodule : lcd_refresh_address_cursor

// ---- lcd_refresh_defines.svh ----
// Behaviour
// - Divide 1/4: one fetch per 8 clocks.
// - Divide 1/8: one fetch per 16 clocks.
// - Divide 1/16: one fetch per 32 clocks.
// - One cursor register: display cursor and access pointer.
// - Each memory access steps cursor in set direction.
// - Two layers: cursor drawn in first layer only.
// - Three layers: cursor drawn in third layer only.
// - Cursor off outside the cursor-capable layer.
// - Cursor vanishes after long absence from screen.
// - Graphics cursor: text block hidden, still addressed.
// - Each layer window splits into two blocks.
// - Line length is nine cycles per address plus one.
// - Fractional dots at right edge are blanked.
// - Dot shift active: one extra fetch per line.
// - Too short line time breaks scan and line pulse; here only the line pulse is suppressed, fetches go on.
// - Next line address advances by virtual pitch.
`ifndef LCD_REFRESH_DEFINES_SVH
`define LCD_REFRESH_DEFINES_SVH
`define ADDR_W              16
`define OFF_CTRL            8'h00
`define OFF_BLK1            8'h04
`define OFF_BLK2            8'h08
`define OFF_BLK3            8'h0c
`define OFF_BLK4            8'h10
`define OFF_PITCH           8'h14
`define OFF_RANGE           8'h18
`define OFF_TOTAL           8'h1c
`define OFF_LINES           8'h20
`define OFF_SL1             8'h24
`define OFF_FX              8'h28
`define OFF_DOTS            8'h2c
`define OFF_CURSOR          8'h30
`define OFF_MEMDATA         8'h34
`define OFF_STATUS          8'h38
`define CTRL_RST            9'h000
`define RANGE_RST           8'h28
`define TOTAL_RST           8'h2e
`define PITCH_RST           8'h29
`define LINES_RST           9'h0f0
`define SL1_RST             9'h078
`define FX_RST              4'h8
`define DOTS_RST            12'h140
`define FETCH_BASE_CYCLES   6'h08
`define TOTAL_MARGIN        9'h004
`define OSC_PER_ADDR        12'h009
`define OSC_EXTRA           12'h001
`define CURSOR_HIDE_MS      300
`define CLK_PERIOD_NS       100
`endif

// ---- lcd_refresh_pkg.sv ----
`include "lcd_refresh_defines.svh"
package lcd_refresh_pkg;
  typedef enum logic [1:0] {DIR_RIGHT, DIR_LEFT, DIR_UP, DIR_DOWN} step_dir_t;
  typedef enum logic [1:0] {DIV_4, DIV_8, DIV_16, DIV_RSVD} div_sel_t;
  typedef struct packed {
    step_dir_t dir;
    logic      hdot_shift;
    logic      gfx_cursor;
    logic      cursor_on;
    logic      three_layer;
    logic      enable;
    div_sel_t  div_sel;
  } ctrl_t;
  typedef struct packed {
    logic [`ADDR_W-1:0] addr_a;
    logic [`ADDR_W-1:0] addr_b;
    logic               show_a;
    logic               cursor;
    logic [3:0]         valid_dots;
  } fetch_t;
  typedef struct packed {
    logic               we;
    logic [`ADDR_W-1:0] addr;
    logic [7:0]         wdata;
  } host_mem_t;
endpackage : lcd_refresh_pkg

// ---- tb_lcd_refresh_address_cursor.sv ----
`timescale 1ns/100ps
`include "lcd_refresh_defines.svh"
module tb_lcd_refresh_address_cursor import lcd_refresh_pkg::*;;
  localparam int HIDE = 3000;
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h0;
  logic [1:0]         htrans = 2'b00;
  logic               hwrite = 1'b0;
  logic [2:0]         hsize = 3'b010;
  logic [31:0]        hwdata = 32'h0;
  logic               hready;
  logic               hreadyout;
  logic               hresp;
  logic [31:0]        hrdata;
  logic [7:0]         mem_rdata;
  logic [`ADDR_W-1:0] mem_rd_addr;
  host_mem_t          host_mem;
  fetch_t             fetch;
  logic               fetch_valid;
  logic               line_latch_pulse;
  logic               frame_start;
  int n_fail = 0, check_count = 0, cyc = 0, n_lp = 0;
  int b1, b2, b3, b4, pitch, rng, tot, lines, sl1, fx, dots, cur, per;
  int t, g, h, m, line, col, last_f, last_l, last_fs;
  bit mon = 0;

  assign hready = hreadyout;
  always #50 hclk = ~hclk;

  lcd_refresh_address_cursor #(.HIDE_CYCLES(HIDE)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mem_rdata(mem_rdata), .mem_rd_addr(mem_rd_addr),
    .host_mem(host_mem), .fetch(fetch), .fetch_valid(fetch_valid),
    .line_latch_pulse(line_latch_pulse), .frame_start(frame_start)
  );

  lcd_mem_model mem_model (
    .hclk(hclk), .host_mem(host_mem), .mem_rd_addr(mem_rd_addr),
    .mem_rdata(mem_rdata)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] v);
    check_count++;
    if (v !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, v);
    end
  endtask : chk

  // One single transfer; the master waits on hready, never on a count.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
    hsel <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'b0, a, 32'h0, r);
  endtask : rd

  task automatic check_fetch();
    int ln, ea, eb, cap, ed;
    bit first;
    first = line < sl1;
    ln = first ? line : line - sl1;
    ea = (first ? b1 : b3) + ln * pitch + col;
    eb = (first ? b2 : b4) + ln * pitch + col;
    cap = t ? eb : ea;
    ed = (fx * col >= dots) ? 0 : dots - fx * col;
    ed = (ed > fx) ? fx : ed;
    if (last_f >= 0)
      chk("fetch_gap", col > 0 ? per : (tot + 2 - rng - h) * per,
          cyc - last_f);
    chk("addr_a", {16'h0, ea[15:0]}, {16'h0, fetch.addr_a});
    chk("addr_b", {16'h0, eb[15:0]}, {16'h0, fetch.addr_b});
    chk("cursor", {31'h0, cap[15:0] == cur[15:0] && m != 3},
        {31'h0, fetch.cursor});
    chk("show_a", {31'h0, g == 0}, {31'h0, fetch.show_a});
    chk("dots", ed, {28'h0, fetch.valid_dots});
    last_f = cyc;
    col++;
    if (col == rng + h) begin
      col = 0;
      line = (line + 1) % lines;
    end
  endtask : check_fetch

  always @(posedge hclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      $display("[ERR] cycle_limit expected 0 seen 1");
      finish_test();
    end
    if (mon && fetch_valid === 1'b1) check_fetch();
    if (mon && line_latch_pulse === 1'b1) begin
      n_lp++;
      if (last_l >= 0) chk("line_gap", (tot + 1) * per, cyc - last_l);
      last_l = cyc;
    end
    if (mon && frame_start === 1'b1 && tot >= rng + 4) begin
      chk("frame_line", 0, line);
      if (last_fs >= 0)
        chk("frame_gap", lines * (tot + 1) * per, cyc - last_fs);
      last_fs = cyc;
    end
  end

  task automatic run(input int dv, input int tt, input int gg,
                     input int hh, input int tl, input int off);
    logic [31:0] r;
    t = tt;
    g = gg;
    h = hh;
    tot = tl;
    per = 8 << dv;
    wr(`OFF_TOTAL, tot);
    m = off;
    cur = (off == 1) ? 32'hffff : ((t ^ (off == 2)) ? b2 : b1) + pitch + 1;
    wr(`OFF_CURSOR, cur);
    line = 0;
    col = 0;
    last_f = -1;
    last_l = -1;
    last_fs = -1;
    n_lp = 0;
    wr(`OFF_CTRL, {25'h0, h[0], g[0], off != 3, t[0], 1'b1, dv[1:0]});
    mon = 1;
    repeat (2 * lines * (tot + 1) * per + (off == 1 ? HIDE + 100 : 8))
      @(posedge hclk);
    mon = 0;
    rd(`OFF_STATUS, r);
    chk("status", {4'h0, 12'(tot * 9 + 1), 14'h0, off == 1, tot < rng + 4},
        r & 32'h0fff0003);
    if (tot < rng + 4) chk("lp_count", 0, n_lp);
    wr(`OFF_CTRL, 32'h0);
  endtask : run

  initial begin
    logic [7:0]  ro [12];
    logic [31:0] rv [12];
    logic [31:0] r, sv;
    int qa [$], em [int], d;
    ro = '{`OFF_CTRL, `OFF_RANGE, `OFF_TOTAL, `OFF_PITCH, `OFF_LINES,
           `OFF_SL1, `OFF_FX, `OFF_DOTS, `OFF_BLK1, `OFF_CURSOR, 8'h3c, 8'h80};
    rv = '{32'h0, 32'h28, 32'h2e, 32'h29, 32'hf0, 32'h78, 32'h8, 32'h140,
           32'h0, 32'h0, 32'h0, 32'h0};
    r = $urandom(2);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    wr(8'h3c, 32'hffffffff);
    for (int i = 0; i < 12; i++) begin
      rd(ro[i], r);
      chk("reset_value", rv[i], r);
    end
    b1 = $urandom % 4096;
    b2 = $urandom % 4096 + 4096;
    b3 = $urandom % 4096 + 8192;
    b4 = $urandom % 4096 + 12288;
    pitch = 5;
    rng = 2;
    lines = 4;
    sl1 = 2;
    fx = 6;
    dots = 10;
    ro = '{`OFF_BLK1, `OFF_BLK2, `OFF_BLK3, `OFF_BLK4, `OFF_PITCH,
           `OFF_RANGE, `OFF_LINES, `OFF_SL1, `OFF_FX, 8'h00, 8'h00, 8'h00};
    rv = '{b1, b2, b3, b4, pitch, rng, lines, sl1, fx, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 9; i++) wr(ro[i], rv[i]);
    wr(`OFF_DOTS, dots);
    cur = 16'h0100 + $urandom % 16'h0e00;
    wr(`OFF_CURSOR, cur);
    for (int dir = 0; dir < 4; dir++) begin
      d = $urandom % 256;
      wr(`OFF_CTRL, {23'h0, dir[1:0], 7'h0});
      wr(`OFF_MEMDATA, d);
      qa.push_back(cur);
      em[cur] = d;
      cur += (dir == 0) ? 1 : (dir == 1) ? -1 : (dir == 2) ? -pitch : pitch;
      rd(`OFF_CURSOR, r);
      chk("cursor_step", cur[15:0], r);
    end
    rd(`OFF_CURSOR, sv);
    foreach (qa[i]) begin
      wr(`OFF_CURSOR, qa[i]);
      rd(`OFF_MEMDATA, r);
      chk("mem_byte", em[qa[i]], r);
    end
    wr(`OFF_CURSOR, sv);
    rd(`OFF_CURSOR, r);
    chk("cursor_restore", sv, r);
    run(0, 0, 0, 0, 6, 0);
    run(1, 1, 0, 1, 6, 0);
    run(2, 0, 1, 0, 6, 0);
    run(0, 1, 1, 1, 7, 2);
    run(0, 0, 0, 0, 4, 3);
    run(0, 0, 0, 0, 6, 1);
    finish_test();
  end
endmodule : tb_lcd_refresh_address_cursor
